// ===== bench/lcf_motor_model.sv
/*
  Behavioural power stage and motor load seen through the current sense path.
  Assumes the bench chooses locked or free rotor and the core clock drives it.
*/
`timescale 1ns/1ps

module lcf_motor_model
  import lcf_pkg::*;
(
  // Clock
  input  wire logic         aclk,
  // Gate command and load choice
  input  lcf_gate_type      gate_cmd,
  input  wire logic         rotor_locked,
  // Sensed current, mA
  output logic [15:0]       current_ma
);

  // Current flows only while the stage runs; a stalled rotor draws far above any low threshold
  always_ff @(posedge aclk) begin
    if (gate_cmd != GATE_RUN) begin
      current_ma <= 16'h0000;  // Stage off or braking, no sensed drive current
    end else begin
      current_ma <= rotor_locked ? 16'h07D0 : 16'h0032;
    end
  end

endmodule // lcf_motor_model

// ===== bench/lock_current_fault_response_tb_top.sv
/*
  Self-checking bench for the lock-current fault response core over AXI4-Lite.
  Assumes lcf_core with TIME_DIV 1000 and the motor model on its current input.
*/
`timescale 1ns/1ps

module lock_current_fault_response_tb_top
  import lcf_pkg::*;
;
  logic aclk = 0, aresetn = 0, rotor_locked = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic awready, wready, bvalid, arready, rvalid, pin_n, irq;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] current_ma;
  lcf_gate_type gate_cmd;
  int error_cnt = 0, check_count = 0;

  // Core clock, 50 ns period
  always #25 aclk = ~aclk;

  lcf_core #(.TIME_DIV(1000)) dut (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .current_ma(current_ma), .gate_cmd(gate_cmd), .fault_indicator_pin_n(pin_n), .irq(irq));

  lcf_motor_model motor (.aclk(aclk), .gate_cmd(gate_cmd), .rotor_locked(rotor_locked),
    .current_ma(current_ma));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Outputs packed as gate, pin, irq; sampled mid-cycle where settled
  task automatic chk_out(input logic [3:0] exp);
    check_count++;
    if ({gate_cmd, pin_n, irq} !== exp) begin
      error_cnt++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, {gate_cmd, pin_n, irq});
    end
  endtask

  // Handshakes judged at the falling edge, then released right after the rising edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, b_t;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    b_t = 0;
    while (!b_t) begin
      @(negedge aclk);
      aw_t = awvalid && awready; w_t = wvalid && wready; b_t = bvalid; resp = bresp;
      @(posedge aclk);
      if (aw_t) awvalid <= 0;
      if (w_t) wvalid <= 0;
      if (b_t) bready <= 0;
    end
  endtask

  task automatic axr(input logic [7:0] a);
    logic ar_t, r_t;
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    r_t = 0;
    while (!r_t) begin
      @(negedge aclk);
      ar_t = arvalid && arready; r_t = rvalid; rd = rdata; resp = rresp;
      @(posedge aclk);
      if (ar_t) arvalid <= 0;
      if (r_t) rready <= 0;
    end
  endtask

  // Bounded wait for the fault pin to reach a level
  task automatic wait_pin(input logic lvl, input int max);
    for (int i = 0; i < max && pin_n !== lvl; i++) @(negedge aclk);
  endtask

  // Clear fault, sticky status and return the rotor to free running
  task automatic recover(input logic [31:0] ctrl);
    @(posedge aclk) rotor_locked <= 0;
    axw(ADDR_CTRL, ctrl | 32'h0000_0001);
    axw(ADDR_STATUS, 32'h0000_0007);
    repeat (40) @(negedge aclk);
  endtask

  function automatic logic [1:0] exp_gate(input logic [3:0] a);
    if (a == 4'h2 || a == 4'h6) return 2'h2;
    if (a == 4'h3 || a == 4'h7) return 2'h3;
    return (a <= 4'h5) ? 2'h1 : 2'h0;
  endfunction

  // Stops a hung run well past the expected length
  initial begin
    #(60000 * 50);
    error_cnt++;
    print_verdict();
  end

  initial begin
    logic [31:0] w;
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    axr(ADDR_SETUP); chk_reg(32'h0000_0000, rd);
    axr(ADDR_STATE); chk_reg(32'h0000_0011, rd);
    axr(8'h20); chk_reg({30'h0, RESP_DECERR}, {30'h0, resp});
    axw(8'h20, 32'h0000_0000); chk_reg({30'h0, RESP_DECERR}, {30'h0, resp});
    // Every action code, threshold 0.125 A, shortest filter, no retries allowed
    for (int a = 0; a < 16; a++) begin
      w = (32'(a) << ACT_LSB) | (32'h2 << DEG_LSB);
      axw(ADDR_SETUP, w);
      axr(ADDR_SETUP); chk_reg(w, rd);
      @(posedge aclk) rotor_locked <= 1;
      if (a >= 9) begin
        repeat (300) @(negedge aclk);
        chk_out({2'h0, 1'b1, 1'b0});
        axr(ADDR_STATUS);
        chk_reg(32'h0000_0000, rd);
      end else begin
        wait_pin(1'b0, 400);
        repeat (100) @(negedge aclk);
        chk_out({exp_gate(4'(a)), 1'b0, 1'b0});
        axr(ADDR_STATUS);
        if (a <= 7) begin
          chk_reg(32'h0000_0003, rd);
        end else begin
          chk_reg(32'h0000_0001, rd);
        end
      end
      recover(32'h0);
      chk_out(4'h2);
    end
    // Two-stage retry: one automatic clear, then latch on the next event
    axw(ADDR_SETUP, (32'h6 << ACT_LSB) | (32'h2 << DEG_LSB));
    axw(ADDR_CTRL, 32'h0000_0010);
    @(posedge aclk) rotor_locked <= 1;
    wait_pin(1'b0, 400);
    axr(ADDR_STATE); chk_reg(32'h0000_0020, rd & 32'h0000_00F0);
    chk_out({2'h2, 1'b0, 1'b0});
    wait_pin(1'b1, 8000);
    axr(ADDR_STATUS); chk_reg(32'h0000_0004, rd & 32'h0000_0004);
    wait_pin(1'b0, 800);
    repeat (3000) @(negedge aclk);
    axr(ADDR_STATE); chk_reg(32'h0000_0048, rd & 32'h0000_00FC);
    recover(32'h0000_0010);
    // Short excursions restart the 25 ms filter, scaled to 500 cycles
    axw(ADDR_SETUP, (32'h2 << ACT_LSB) | (32'h9 << DEG_LSB));
    repeat (5) begin
      @(posedge aclk) rotor_locked <= 1;
      repeat (300) @(posedge aclk);
      rotor_locked <= 0;
      repeat (20) @(posedge aclk);
    end
    chk_out(4'h2);
    @(posedge aclk) rotor_locked <= 1;
    repeat (400) @(negedge aclk);
    chk_out(4'h2);
    wait_pin(1'b0, 400);
    chk_out({2'h2, 1'b0, 1'b0});
    // Masked, unmasked and cleared interrupt
    axw(ADDR_MASK, 32'h0000_0002);
    repeat (3) @(negedge aclk);
    chk_out({2'h2, 1'b0, 1'b1});
    axw(ADDR_STATUS, 32'h0000_0002);
    repeat (3) @(negedge aclk);
    chk_out({2'h2, 1'b0, 1'b0});
    recover(32'h0);
    chk_out(4'h2);
    // Locked rotor draws 2.0 A: no event at a 2.5 A threshold, event at 1.5 A
    axw(ADDR_SETUP, (32'h6 << THR_LSB) | (32'h2 << ACT_LSB) | (32'h2 << DEG_LSB));
    @(posedge aclk) rotor_locked <= 1;
    repeat (300) @(negedge aclk);
    chk_out(4'h2);
    axw(ADDR_SETUP, (32'h4 << THR_LSB) | (32'h2 << ACT_LSB) | (32'h2 << DEG_LSB));
    wait_pin(1'b0, 400);
    chk_out({2'h2, 1'b0, 1'b1});
    recover(32'h0);
    chk_out(4'h2);
    print_verdict();
  end

endmodule // lock_current_fault_response_tb_top

// ===== design/lcf_core.sv
/*
  Lock-current fault response: deglitch filter, latched, retry, report-only
  and disabled actions, gate command, fault indicator, AXI4-Lite registers and
  interrupt. Assumes the measured current arrives in mA on the core clock.
*/
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// Operation
// R1: Action 0h/1h latches fault, indicator, tristate
// R2: Action 2h latches fault, indicator, high-side brake
// R3: Action 3h latches fault, indicator, low-side brake
// R4: Action 4h/5h retry, then latch tristated
// R5: Action 6h retry, then latch high-side brake
// R6: Action 7h retry, then latch low-side brake
// R7: Retries counted, latch beyond programmed limit
// R8: Action 8h only reports, stage unchanged
// R9: Actions 9h-Fh ignore lock-current events
// R10: Action field bits 18-15, reset zero
// R11: Filter time bits 14-11, coded table
// R12: Retry wait coded 300 ms to 14 s
// R13: Threshold coded 0.125 A to 8 A
// R14: Event only after continuous over-threshold time
// R15: Latched fault holds until clear or reset
module lcf_core
  import lcf_pkg::*;
#(
  parameter int TIME_DIV = 1  // Divides every filter and wait time, for simulation
) (
  // Clock, reset, enable
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                ce,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Measured phase current, mA
  input  wire logic [15:0]         current_ma,
  // Gate driver command and fault pin
  output lcf_gate_type             gate_cmd,
  output logic                     fault_indicator_pin_n,
  output logic                     irq
);

  // Scales a table time to timer ticks, never below one
  function automatic logic [TIM_W-1:0] ticks(input int us);
    int t;
    t = us / TIME_DIV;
    return (t < 1) ? TIM_W'(1) : TIM_W'(t);
  endfunction

  // Merges byte lanes of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Bus state
  logic                aw_q, aw_d;
  logic                w_q, w_d;
  logic [ADDR_W-1:0]   awaddr_q, awaddr_d;
  logic [31:0]         wdata_q, wdata_d;
  logic [3:0]          wstrb_q, wstrb_d;
  logic                bvalid_q, bvalid_d;
  logic [1:0]          bresp_q, bresp_d;
  logic                rvalid_q, rvalid_d;
  logic [1:0]          rresp_q, rresp_d;
  logic [31:0]         rdata_q, rdata_d;
  logic                wr_go;

  // Register and core state
  logic [31:0]         setup_q, setup_d;
  logic [FLD_W-1:0]    limit_q, limit_d;
  logic [ST_W-1:0]     sts_q, sts_d;
  logic [ST_W-1:0]     mask_q, mask_d;
  lcf_state_type       st_q, st_d;
  logic [3:0]          act_q, act_d;
  logic [FLD_W-1:0]    rcnt_q, rcnt_d;
  logic [TIM_W-1:0]    tim_q, tim_d;
  logic [PRE_W-1:0]    pre_q, pre_d;
  lcf_gate_type        gate_q, gate_d;
  logic                fault_n_q, fault_n_d;
  logic                irq_q, irq_d;

  // Decoded fields and events
  logic [3:0]          mode;
  logic                over;
  logic                us_tick;
  logic                ev;
  logic                clr;
  logic [ST_W-1:0]     set_bits;
  logic [ST_W-1:0]     w1c_bits;
  logic [31:0]         rd_word;

  assign mode    = setup_q[ACT_LSB +: FLD_W];
  assign over    = current_ma > thr_ma(setup_q[THR_LSB +: FLD_W]);  // R13
  assign us_tick = pre_q == PRE_W'(CYC_PER_US - 1);

  // Handshakes stall while frozen so no beat is lost
  assign s_axi_awready = ce && !aw_q && !bvalid_q;
  assign s_axi_wready  = ce && !w_q && !bvalid_q;
  assign s_axi_arready = ce && !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign gate_cmd              = gate_q;
  assign fault_indicator_pin_n = fault_n_q;
  assign irq                   = irq_q;

  // Read mux; unused bits read as zero, except in the setup word, which reads back every written bit
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      ADDR_SETUP:  rd_word = setup_q;
      ADDR_CTRL:   rd_word[LIM_LSB +: FLD_W] = limit_q;
      ADDR_STATUS: rd_word[ST_W-1:0] = sts_q;
      ADDR_MASK:   rd_word[ST_W-1:0] = mask_q;
      ADDR_STATE:  rd_word = {20'h0_0000, rcnt_q, st_q, 2'(gate_q), 1'b0, fault_n_q};
      default:     rd_word = 32'h0000_0000;
    endcase
  end

  // Bus next state: address and data may come in either order
  always_comb begin
    aw_d     = aw_q;
    w_d      = w_q;
    awaddr_d = awaddr_q;
    wdata_d  = wdata_q;
    wstrb_d  = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    wr_go    = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d     = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d     = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (aw_q && w_q) begin
      wr_go    = 1'b1;
      aw_d     = 1'b0;
      w_d      = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = (awaddr_q == ADDR_SETUP || awaddr_q == ADDR_CTRL || awaddr_q == ADDR_STATUS
                  || awaddr_q == ADDR_MASK || awaddr_q == ADDR_STATE) ? RESP_OKAY : RESP_DECERR;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rdata_d  = rd_word;
      rresp_d  = (rd_word == 32'h0000_0000 && s_axi_araddr > ADDR_STATE) ? RESP_DECERR : RESP_OKAY;
    end
  end

  // Bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (ce) begin
      aw_q     <= aw_d;
      w_q      <= w_d;
      awaddr_q <= awaddr_d;
      wdata_q  <= wdata_d;
      wstrb_q  <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
    end
  end

  // Core next state: registers, filter, fault sequencer, outputs
  always_comb begin
    setup_d  = setup_q;
    limit_d  = limit_q;
    mask_d   = mask_q;
    st_d     = st_q;
    act_d    = act_q;
    rcnt_d   = rcnt_q;
    tim_d    = tim_q;
    pre_d    = us_tick ? PRE_W'(0) : pre_q + PRE_W'(1);
    ev       = 1'b0;
    clr      = 1'b0;
    set_bits = '0;
    w1c_bits = '0;
    if (wr_go) begin
      unique case (awaddr_q)
        ADDR_SETUP:  setup_d = merge(setup_q, wdata_q, wstrb_q);  // R10 R11 R12
        ADDR_CTRL: begin
          if (wstrb_q[0]) begin
            limit_d = wdata_q[LIM_LSB +: FLD_W];
            clr     = wdata_q[CLR_BIT];
          end
        end
        ADDR_STATUS: w1c_bits = wstrb_q[0] ? wdata_q[ST_W-1:0] : '0;
        ADDR_MASK:   mask_d = wstrb_q[0] ? wdata_q[ST_W-1:0] : mask_q;
        default: ;
      endcase
    end
    unique case (st_q)
      S_RUN: begin
        // Any dip below threshold restarts the filter
        if (over && mode <= ACT_REPORT) begin  // R9
          if (tim_q >= ticks(deg_us(setup_q[DEG_LSB +: FLD_W]))) begin  // R14 R11
            ev = 1'b1;
          end else if (us_tick) begin
            tim_d = tim_q + TIM_W'(1);
          end
        end else begin
          tim_d = '0;  // R14
        end
        if (ev) begin
          tim_d              = '0;
          act_d              = mode;
          set_bits[ST_EVENT] = 1'b1;
          if (mode == ACT_REPORT) begin
            st_d = S_REPORT;  // R8
          end else if (mode < ACT_RTY_LO) begin
            st_d               = S_LATCH;  // R1 R2 R3
            set_bits[ST_LATCH] = 1'b1;
          end else if (rcnt_q >= limit_q) begin
            st_d               = S_LATCH;  // R4 R5 R6 R7
            set_bits[ST_LATCH] = 1'b1;
          end else begin
            st_d   = S_RETRY;
            rcnt_d = rcnt_q + FLD_W'(1);  // R7
          end
        end
      end
      S_RETRY: begin
        if (tim_q >= ticks(wait_us(setup_q[WAIT_LSB +: FLD_W]))) begin  // R12 R4
          st_d               = S_RUN;
          tim_d              = '0;
          set_bits[ST_RETRY] = 1'b1;
        end else if (us_tick) begin
          tim_d = tim_q + TIM_W'(1);
        end
      end
      S_LATCH:  st_d = S_LATCH;  // R15
      S_REPORT: st_d = S_REPORT;
    endcase
    // Explicit clear releases every fault and the retry budget
    if (clr) begin
      st_d   = S_RUN;  // R15
      tim_d  = '0;
      rcnt_d = '0;
    end
    // Set wins over a clear in the same cycle
    sts_d     = (sts_q & ~w1c_bits) | set_bits;
    irq_d     = |(sts_d & mask_d);
    gate_d    = (st_d == S_LATCH || st_d == S_RETRY) ? gate_of(act_d) : GATE_RUN;  // R1 R2 R3
    fault_n_d = (st_d == S_RUN);  // R8
  end

  // Core registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setup_q   <= SETUP_RESET;  // R10
      limit_q   <= '0;
      sts_q     <= '0;
      mask_q    <= '0;
      st_q      <= S_RUN;
      act_q     <= 4'h0;
      rcnt_q    <= '0;
      tim_q     <= '0;
      pre_q     <= '0;
      gate_q    <= GATE_RUN;
      fault_n_q <= 1'b1;
      irq_q     <= 1'b0;
    end else if (ce) begin
      setup_q   <= setup_d;
      limit_q   <= limit_d;
      sts_q     <= sts_d;
      mask_q    <= mask_d;
      st_q      <= st_d;
      act_q     <= act_d;
      rcnt_q    <= rcnt_d;
      tim_q     <= tim_d;
      pre_q     <= pre_d;
      gate_q    <= gate_d;
      fault_n_q <= fault_n_d;
      irq_q     <= irq_d;
    end
  end

  // Checks hold only while the clock is enabled
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  a_latch_tristate: assert property ((st_q == S_LATCH && act_q <= 4'h1)   // R1
    |-> gate_q == GATE_HIZ && !fault_indicator_pin_n) else $error("latched hi-z wrong");
  a_latch_hs_brake: assert property ((ev && mode == ACT_HSB_L && !clr)    // R2
    |=> st_q == S_LATCH && gate_q == GATE_HSB && !fault_indicator_pin_n) else $error("hs brake wrong");
  a_latch_ls_brake: assert property ((ev && mode == ACT_LSB_L && !clr)    // R3
    |=> st_q == S_LATCH && gate_q == GATE_LSB && !fault_indicator_pin_n) else $error("ls brake wrong");
  a_retry_exceed_latch: assert property ((ev && mode >= ACT_RTY_LO && mode <= ACT_LSB_R  // R4
    && rcnt_q >= limit_q && !clr) |=> st_q == S_LATCH && gate_q == gate_of(act_q))
    else $error("retry limit did not latch");
  a_retry_count_step: assert property ((ev && mode >= ACT_RTY_LO && mode <= ACT_LSB_R  // R7
    && rcnt_q < limit_q && !clr) |=> st_q == S_RETRY && rcnt_q == $past(rcnt_q) + 4'h1)
    else $error("retry count did not step");
  a_retry_wait_ends: assert property ((st_q == S_RETRY && !clr  // R5 R6
    && tim_q >= ticks(wait_us(setup_q[WAIT_LSB +: FLD_W]))) |=> st_q == S_RUN && fault_indicator_pin_n)
    else $error("retry did not auto-clear");
  a_report_only: assert property ((st_q == S_REPORT)                      // R8
    |-> gate_q == GATE_RUN && !fault_indicator_pin_n) else $error("report changed stage");
  a_disabled_ignore: assert property ((mode > ACT_REPORT && st_q == S_RUN) // R9
    |-> !ev ##1 fault_indicator_pin_n) else $error("disabled mode raised fault");
  a_filter_needs_over: assert property ((st_q == S_RUN && !over) |=> tim_q == '0 && !$past(ev)) // R14
    else $error("filter did not restart");
  a_latch_persists: assert property ((st_q == S_LATCH && !clr) |=> st_q == S_LATCH) // R15
    else $error("latched fault released");

  c_latched: cover property (ev ##1 st_q == S_LATCH);
  c_retry_round: cover property (st_q == S_RETRY ##1 st_q == S_RUN);
  c_report: cover property (ev ##1 st_q == S_REPORT);
  c_irq: cover property ($rose(irq));

endmodule  // lcf_core

// ===== design/lcf_pkg.sv
/*
  Constants, field layouts, codes and time tables for the lock-current
  fault response block. Assumes a 20 MHz core clock and a 32-bit AXI4-Lite bus.
*/
package lcf_pkg;

  // Clock and time base
  localparam int CLK_HZ     = 20_000_000;
  localparam int US_PER_S   = 1_000_000;
  localparam int CYC_PER_US = CLK_HZ / US_PER_S;
  localparam int PRE_W      = 5;
  localparam int TIM_W      = 24;

  // Register byte addresses
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  ADDR_SETUP    = 8'h00;  // fault_setup_word_one
  localparam logic [7:0]  ADDR_CTRL     = 8'h04;  // fault_control
  localparam logic [7:0]  ADDR_STATUS   = 8'h08;  // fault_status, write one to clear
  localparam logic [7:0]  ADDR_MASK     = 8'h0C;  // fault_irq_mask
  localparam logic [7:0]  ADDR_STATE    = 8'h10;  // fault_state, read only
  localparam logic [31:0] SETUP_RESET   = 32'h0000_0000;

  // Field positions
  localparam int THR_LSB    = 19;  // lock_current_threshold
  localparam int ACT_LSB    = 15;  // lock_current_fault_action
  localparam int DEG_LSB    = 11;  // lock_current_filter_time
  localparam int WAIT_LSB   = 7;   // lock_retry_wait
  localparam int CLR_BIT    = 0;   // fault_control: fault clear, self clearing
  localparam int LIM_LSB    = 4;   // fault_control: retry_attempt_limit
  localparam int FLD_W      = 4;

  // Status and mask bits
  localparam int ST_W       = 3;
  localparam int ST_EVENT   = 0;
  localparam int ST_LATCH   = 1;
  localparam int ST_RETRY   = 2;

  // Action codes
  localparam logic [3:0] ACT_HSB_L  = 4'h2;
  localparam logic [3:0] ACT_LSB_L  = 4'h3;
  localparam logic [3:0] ACT_RTY_LO = 4'h4;
  localparam logic [3:0] ACT_HSB_R  = 4'h6;
  localparam logic [3:0] ACT_LSB_R  = 4'h7;
  localparam logic [3:0] ACT_REPORT = 4'h8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    GATE_RUN = 2'h0,
    GATE_HIZ = 2'h1,
    GATE_HSB = 2'h2,
    GATE_LSB = 2'h3
  } lcf_gate_type;

  typedef enum logic [3:0] {
    S_RUN    = 4'h1,
    S_RETRY  = 4'h2,
    S_LATCH  = 4'h4,
    S_REPORT = 4'h8
  } lcf_state_type;

  // Filter time in microseconds; codes 0h and 1h fall back to the shortest
  function automatic int deg_us(input logic [3:0] code);
    int t [16] = '{200, 200, 200, 500, 1000, 2500, 5000, 7500, 10000, 25000,
                   50000, 75000, 100000, 200000, 500000, 1000000};
    return t[code];
  endfunction

  // Retry wait in microseconds
  function automatic int wait_us(input logic [3:0] code);
    int t [16] = '{300000, 500000, 1000000, 2000000, 3000000, 4000000, 5000000, 6000000,
                   7000000, 8000000, 9000000, 10000000, 11000000, 12000000, 13000000, 14000000};
    return t[code];
  endfunction

  // Threshold in milliamperes
  function automatic logic [15:0] thr_ma(input logic [3:0] code);
    logic [15:0] t [16] = '{16'h007D, 16'h00FA, 16'h01F4, 16'h03E8, 16'h05DC, 16'h07D0,
                            16'h09C4, 16'h0BB8, 16'h0DAC, 16'h0FA0, 16'h1194, 16'h1388,
                            16'h157C, 16'h1770, 16'h1B58, 16'h1F40};
    return t[code];
  endfunction

  // Power stage state held while a latched or retrying fault is in force
  function automatic lcf_gate_type gate_of(input logic [3:0] act);
    if (act == ACT_HSB_L || act == ACT_HSB_R) begin
      return GATE_HSB;
    end else if (act == ACT_LSB_L || act == ACT_LSB_R) begin
      return GATE_LSB;
    end
    return GATE_HIZ;
  endfunction

endpackage
